/* inc/annun_cfg_map.svh */
`ifndef ANNUN_CFG_MAP_SVH
`define ANNUN_CFG_MAP_SVH

`define CLK_PERIOD_NS 100
`define MS_NS         1000000
`define DEB_MS        5'h14
`define HOLD_MS       13'h1388
`define IDLE_MS       20'h927c0
`define FLASH_MS      10'h3e8
`define EXIT_SHOW_MS  20'h00bb8

`define BATT_DEF      3'h1
`define BATT_LAST     3'h4
`define NEG_POL_DEF   1'b1
`define ADDR_DEF      2'h0
`define HORN_DEF      2'h2
`define HORN_OFF      2'h0
`define LAMP_DEF      3'h0
`define LAMP_LAST     3'h6
`define LAMP_FLASH0   3'h3
`define LAST_LAMP     5'h13
`define FUNC_LAST     3'h7

`define COL_OFF       2'h0
`define COL_GREEN     2'h1
`define COL_AMBER     2'h2
`define COL_RED       2'h3

`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_IRQ_STAT  8'h08
`define REG_IRQ_MASK  8'h0c
`define REG_SETTINGS  8'h10
`define REG_ALERT     8'h14
`define REG_INVERT    8'h18
`define REG_ACTIVE    8'h1c

`define CTRL_ENTER    0
`define CTRL_SILENCE  1
`define IRQ_ENTERED   0
`define IRQ_SAVED     1
`define IRQ_HORN      2

`endif

/* inc/annun_cfg_pkg.sv */
package annun_cfg_pkg;

  typedef enum logic [2:0] {
    MODE_RUN  = 3'b001,
    MODE_CFG  = 3'b010,
    MODE_EXIT = 3'b100
  } mode_e;

  typedef struct packed {
    logic       level;
    logic [4:0] cnt;
  } deb_s;

  typedef struct packed {
    logic [2:0]       batt;
    logic             neg_pol;
    logic [1:0]       addr;
    logic [1:0]       horn_lvl;
    logic [19:0][2:0] lamp_cfg;
    logic [19:0]      alert;
    logic [19:0]      invert;
  } cfg_s;

  typedef struct packed {
    mode_e            mode;
    logic [2:0]       func;
    logic [4:0]       sel;
    cfg_s             cfg;
    logic [13:0]      div;
    logic [9:0]       ms;
    logic [19:0]      idle;
    logic [12:0]      hold;
    logic             hold_done;
    deb_s             db_f;
    deb_s             db_l;
    deb_s             db_v;
    logic [19:0]      act_prev;
    logic [19:0][1:0] lamp;
    logic [2:0]       ind;
    logic             horn_on;
    logic             horn_loud;
    logic             save;
    logic [2:0]       irq_stat;
    logic [2:0]       irq_mask;
    logic [31:0]      rdata;
  } st_s;

endpackage

/* hw/annunciator_config_menu.sv */
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "annun_cfg_map.svh"
module annunciator_config_menu #(
  parameter int unsigned MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // Operator buttons, high while pressed.
  input  wire logic                 function_select_button,
  input  wire logic                 lamp_step_button,
  input  wire logic                 value_step_button,
  // Hardware inputs.
  input  wire logic [19:0]          hw_inputs,
  // Front panel.
  output logic [19:0][1:0]          lamp_color,
  output logic                      config_indicator_a,
  output logic                      config_indicator_b,
  output logic                      config_indicator_c,
  output logic                      horn_on,
  output logic                      horn_loud,
  // Persistent storage.
  output logic                      save_strobe,
  output annun_cfg_pkg::cfg_s       cfg_out,
  // Register port.
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  output logic                      irq
);

  annun_cfg_pkg::st_s s_ff;
  annun_cfg_pkg::st_s nxt_s;

  function automatic annun_cfg_pkg::deb_s deb(input annun_cfg_pkg::deb_s d,
                                              input logic raw,
                                              input logic tick);
    deb = d;
    if (raw == d.level) begin
      deb.cnt = 5'h00;
    end else if (tick) begin
      if (d.cnt == `DEB_MS - 5'h01) begin
        deb.level = raw;
        deb.cnt = 5'h00;
      end else begin
        deb.cnt = d.cnt + 5'h01;
      end
    end
  endfunction

  function automatic logic [2:0] inc_wrap(input logic [2:0] v, input logic [2:0] last);
    inc_wrap = (v == last) ? 3'h0 : v + 3'h1;
  endfunction

  // Colour of a lamp setting; flashing settings are lit only while on is high.
  function automatic logic [1:0] show(input logic [2:0] c, input logic on);
    show = `COL_OFF;
    if (c < `LAMP_FLASH0) begin
      show = c[1:0] + 2'h1;
    end else if (c < `LAMP_LAST) begin
      show = on ? 2'(c - `LAMP_FLASH0 + 3'h1) : `COL_OFF;
    end
  endfunction

  function automatic logic [1:0] two_col(input logic red);
    two_col = red ? `COL_RED : `COL_GREEN;
  endfunction

  logic             tick;
  logic             p_f;
  logic             p_l;
  logic             p_v;
  logic             long_hold;
  logic             slow_on;
  logic             dbl_on;
  logic             blink_off;
  logic [19:0]      active;
  logic [19:0]      rise;
  logic [2:0]       irq_set;
  logic [2:0]       irq_clr;
  logic             wr_ctrl;
  logic [1:0]       batt_col;
  logic [19:0][1:0] lamp_n;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.save = 1'b0;
    irq_set = 3'h0;
    tick = (s_ff.div == 14'(MS_CYCLES - 1));
    nxt_s.div = tick ? 14'h0000 : s_ff.div + 14'h0001;
    if (tick) begin
      nxt_s.ms = (s_ff.ms == `FLASH_MS - 10'h001) ? 10'h000 : s_ff.ms + 10'h001;
    end
    slow_on = (s_ff.ms < (`FLASH_MS >> 1));
    dbl_on = (s_ff.ms[9:7] == 3'h0) || (s_ff.ms[9:7] == 3'h2);

    // Debounced presses each give a single step.
    nxt_s.db_f = deb(s_ff.db_f, function_select_button, tick);
    nxt_s.db_l = deb(s_ff.db_l, lamp_step_button, tick);
    nxt_s.db_v = deb(s_ff.db_v, value_step_button, tick);
    p_f = nxt_s.db_f.level & ~s_ff.db_f.level;
    p_l = nxt_s.db_l.level & ~s_ff.db_l.level;
    p_v = nxt_s.db_v.level & ~s_ff.db_v.level;

    // A held select button fires once after five seconds.
    long_hold = 1'b0;
    if (!nxt_s.db_f.level) begin
      nxt_s.hold = 13'h0000;
      nxt_s.hold_done = 1'b0;
    end else if (tick && !s_ff.hold_done) begin
      if (s_ff.hold == `HOLD_MS - 13'h0001) begin
        nxt_s.hold_done = 1'b1;
        long_hold = 1'b1;
      end else begin
        nxt_s.hold = s_ff.hold + 13'h0001;
      end
    end

    wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);

    case (s_ff.mode)
      annun_cfg_pkg::MODE_RUN: begin
        if (long_hold || (wr_ctrl && reg_wdata[`CTRL_ENTER])) begin
          nxt_s.mode = annun_cfg_pkg::MODE_CFG;
          nxt_s.func = 3'h1;
          nxt_s.sel = 5'h00;
          nxt_s.idle = 20'h00000;
          irq_set[`IRQ_ENTERED] = 1'b1;
        end
      end
      annun_cfg_pkg::MODE_CFG: begin
        if (p_f || p_l || p_v) begin
          nxt_s.idle = 20'h00000;
        end else if (tick) begin
          nxt_s.idle = s_ff.idle + 20'h00001;
        end
        if (long_hold || (tick && s_ff.idle == `IDLE_MS - 20'h00001)) begin
          nxt_s.mode = annun_cfg_pkg::MODE_EXIT;
          nxt_s.idle = 20'h00000;
          nxt_s.save = 1'b1;
          irq_set[`IRQ_SAVED] = 1'b1;
        end else begin
          if (p_f) begin
            nxt_s.func = (s_ff.func == `FUNC_LAST) ? 3'h1 : s_ff.func + 3'h1;
            nxt_s.sel = 5'h00;
          end
          if (p_l) begin
            nxt_s.sel = (s_ff.sel == `LAST_LAMP) ? 5'h00 : s_ff.sel + 5'h01;
          end
          if (p_v) begin
            case (s_ff.func)
              3'h1: begin
                nxt_s.cfg.batt = inc_wrap(s_ff.cfg.batt, `BATT_LAST);
              end
              3'h2: begin
                nxt_s.cfg.neg_pol = ~s_ff.cfg.neg_pol;
              end
              3'h3: begin
                nxt_s.cfg.addr = s_ff.cfg.addr + 2'h1;
              end
              3'h4: begin
                nxt_s.cfg.lamp_cfg[s_ff.sel] =
                  inc_wrap(s_ff.cfg.lamp_cfg[s_ff.sel], `LAMP_LAST);
                if (nxt_s.cfg.lamp_cfg[s_ff.sel] == `LAMP_LAST) begin
                  nxt_s.cfg.alert[s_ff.sel] = 1'b0;
                end
              end
              3'h5: begin
                if (s_ff.cfg.lamp_cfg[s_ff.sel] != `LAMP_LAST) begin
                  nxt_s.cfg.alert[s_ff.sel] = ~s_ff.cfg.alert[s_ff.sel];
                end
              end
              3'h6: begin
                nxt_s.cfg.invert[s_ff.sel] = ~s_ff.cfg.invert[s_ff.sel];
              end
              3'h7: begin
                nxt_s.cfg.horn_lvl = (s_ff.cfg.horn_lvl == `HORN_DEF) ?
                                     `HORN_OFF : s_ff.cfg.horn_lvl + 2'h1;
              end
              default: begin
              end
            endcase
          end
        end
      end
      annun_cfg_pkg::MODE_EXIT: begin
        if (tick) begin
          nxt_s.idle = s_ff.idle + 20'h00001;
          if (s_ff.idle == `EXIT_SHOW_MS - 20'h00001) begin
            nxt_s.mode = annun_cfg_pkg::MODE_RUN;
          end
        end
      end
      default: begin
        nxt_s.mode = annun_cfg_pkg::MODE_RUN;
      end
    endcase

    // Input qualification and horn.
    active = (s_ff.cfg.neg_pol ? ~hw_inputs : hw_inputs) ^ s_ff.cfg.invert;
    nxt_s.act_prev = active;
    rise = active & ~s_ff.act_prev & s_ff.cfg.alert;
    if ((s_ff.mode != annun_cfg_pkg::MODE_RUN) || (s_ff.cfg.horn_lvl == `HORN_OFF) ||
        !(|(active & s_ff.cfg.alert)) ||
        (wr_ctrl && reg_wdata[`CTRL_SILENCE])) begin
      nxt_s.horn_on = 1'b0;
    end else if (|rise) begin
      nxt_s.horn_on = 1'b1;
      irq_set[`IRQ_HORN] = 1'b1;
    end
    nxt_s.horn_loud = (s_ff.cfg.horn_lvl == `HORN_DEF);

    // Lamp patterns.
    case (s_ff.cfg.batt)
      3'h0: batt_col = `COL_GREEN;
      3'h1: batt_col = `COL_AMBER;
      3'h3: batt_col = `COL_AMBER;
      default: batt_col = `COL_RED;
    endcase
    for (int i = 0; i < 20; i++) begin
      blink_off = (s_ff.sel == 5'(i)) && !slow_on;
      lamp_n[i] = `COL_OFF;
      if (s_ff.mode == annun_cfg_pkg::MODE_CFG) begin
        case (s_ff.func)
          3'h1: begin
            if ((i >= 10) && (i <= 11)) begin
              lamp_n[i] = batt_col;
            end else if ((i == 12) && (s_ff.cfg.batt < 3'h3)) begin
              lamp_n[i] = batt_col;
            end
          end
          3'h2: begin
            lamp_n[i] = two_col(s_ff.cfg.neg_pol);
          end
          3'h3: begin
            if (2'(i) == s_ff.cfg.addr && i < 4) begin
              lamp_n[i] = `COL_GREEN;
            end
          end
          3'h4: begin
            if (s_ff.sel == 5'(i)) begin
              lamp_n[i] = (s_ff.cfg.lamp_cfg[i] >= `LAMP_FLASH0) ?
                          show(s_ff.cfg.lamp_cfg[i], dbl_on) :
                          (slow_on ? show(s_ff.cfg.lamp_cfg[i], 1'b1) : `COL_OFF);
            end else begin
              lamp_n[i] = show(s_ff.cfg.lamp_cfg[i], slow_on);
            end
          end
          3'h5: begin
            lamp_n[i] = blink_off ? `COL_OFF : two_col(s_ff.cfg.alert[i]);
          end
          3'h6: begin
            lamp_n[i] = blink_off ? `COL_OFF : two_col(s_ff.cfg.invert[i]);
          end
          3'h7: begin
            if (i == 0) begin
              lamp_n[i] = s_ff.cfg.horn_lvl + 2'h1;
            end
          end
          default: begin
          end
        endcase
      end else if (active[i]) begin
        lamp_n[i] = show(s_ff.cfg.lamp_cfg[i], slow_on);
      end
    end
    nxt_s.lamp = lamp_n;

    case (s_ff.mode)
      annun_cfg_pkg::MODE_CFG: nxt_s.ind = s_ff.func;
      annun_cfg_pkg::MODE_EXIT: nxt_s.ind = {slow_on, 2'h0};
      default: nxt_s.ind = 3'h0;
    endcase

    // Register port.
    irq_clr = 3'h0;
    if (reg_wr && (reg_addr == `REG_IRQ_STAT)) begin
      irq_clr = reg_wdata[2:0];
    end
    if (reg_wr && (reg_addr == `REG_IRQ_MASK)) begin
      nxt_s.irq_mask = reg_wdata[2:0];
    end
    nxt_s.irq_stat = (s_ff.irq_stat & ~irq_clr) | irq_set;
    nxt_s.rdata = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr == `REG_STATUS) begin
        nxt_s.rdata = {20'h00000, s_ff.horn_on, s_ff.sel, s_ff.func, s_ff.mode};
      end else if (reg_addr == `REG_IRQ_STAT) begin
        nxt_s.rdata = {29'h00000000, s_ff.irq_stat};
      end else if (reg_addr == `REG_IRQ_MASK) begin
        nxt_s.rdata = {29'h00000000, s_ff.irq_mask};
      end else if (reg_addr == `REG_SETTINGS) begin
        nxt_s.rdata = {24'h000000, s_ff.cfg.horn_lvl, s_ff.cfg.addr,
                       s_ff.cfg.neg_pol, s_ff.cfg.batt};
      end else if (reg_addr == `REG_ALERT) begin
        nxt_s.rdata = {12'h000, s_ff.cfg.alert};
      end else if (reg_addr == `REG_INVERT) begin
        nxt_s.rdata = {12'h000, s_ff.cfg.invert};
      end else if (reg_addr == `REG_ACTIVE) begin
        nxt_s.rdata = {12'h000, s_ff.act_prev};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
      s_ff.mode <= annun_cfg_pkg::MODE_RUN;
      s_ff.cfg.batt <= `BATT_DEF;
      s_ff.cfg.neg_pol <= `NEG_POL_DEF;
      s_ff.cfg.addr <= `ADDR_DEF;
      s_ff.cfg.horn_lvl <= `HORN_DEF;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lamp_color = s_ff.lamp;
  assign config_indicator_a = s_ff.ind[0];
  assign config_indicator_b = s_ff.ind[1];
  assign config_indicator_c = s_ff.ind[2];
  assign horn_on = s_ff.horn_on;
  assign horn_loud = s_ff.horn_loud;
  assign save_strobe = s_ff.save;
  assign cfg_out = s_ff.cfg;
  assign reg_rdata = s_ff.rdata;
  assign irq = |(s_ff.irq_stat & s_ff.irq_mask);

endmodule

/* tb/annun_cfg_chk.sv */
`timescale 1ns/1ns
module annun_cfg_chk (
  // Clock and reset.
  input wire logic                clk_sys,
  input wire logic                rst_b,
  // Front panel.
  input wire logic [19:0][1:0]    lamp_color,
  input wire logic                config_indicator_a,
  input wire logic                config_indicator_b,
  input wire logic                config_indicator_c,
  input wire logic                horn_on,
  // Storage.
  input wire logic                save_strobe,
  input wire annun_cfg_pkg::cfg_s cfg_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic [19:0] dis_alert;
  logic [3:0]  addr_green;
  logic        ia;
  logic        ib;
  logic        ic;
  assign ia = config_indicator_a;
  assign ib = config_indicator_b;
  assign ic = config_indicator_c;
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      dis_alert[i] = cfg_out.alert[i] && (cfg_out.lamp_cfg[i] == 3'h6);
    end
    for (int i = 0; i < 4; i++) begin
      addr_green[i] = (lamp_color[i] == 2'h1);
    end
  end
  AST_SAVE_PULSE: assert property (save_strobe |=> !save_strobe)
    else $error("save strobe longer than one cycle");
  AST_SAVE_EXIT: assert property (save_strobe |-> ##2 (!ia && !ib))
    else $error("menu indicators still lit after exit");
  AST_HORN_OFF: assert property (horn_on |-> cfg_out.horn_lvl != 2'h0)
    else $error("horn sounds while disabled");
  AST_HORN_CFG: assert property (ia |-> ##1 !horn_on)
    else $error("horn sounds in configuration");
  AST_ALERT_DIS: assert property (dis_alert == 20'h0)
    else $error("alert enabled on disabled lamp");
  AST_BATT_RANGE: assert property (cfg_out.batt <= 3'h4)
    else $error("battery setting out of range");
  AST_HORN_RANGE: assert property (cfg_out.horn_lvl <= 2'h2)
    else $error("horn level out of range");
  AST_POL_SHOW: assert property ((!ia && ib && !ic)[*2] |->
    (lamp_color == {20{2'h1}} || lamp_color == {20{2'h3}}))
    else $error("polarity display not uniform");
  AST_ADDR_SHOW: assert property ((ia && ib && !ic)[*2] |->
    ($onehot(addr_green) && lamp_color[19:4] == 32'h0))
    else $error("address display not one-hot");
  AST_BATT_SHOW: assert property ((ia && !ib && !ic)[*2] |->
    (lamp_color[10] != 2'h0 && lamp_color[11] == lamp_color[10]))
    else $error("battery display wrong");
  cover property (save_strobe);
  cover property (horn_on);
  cover property (ia && ib && ic);
endmodule
bind annunciator_config_menu annun_cfg_chk i_annun_cfg_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .lamp_color(lamp_color),
  .config_indicator_a(config_indicator_a), .config_indicator_b(config_indicator_b),
  .config_indicator_c(config_indicator_c), .horn_on(horn_on),
  .save_strobe(save_strobe), .cfg_out(cfg_out));

/* tb/annun_operator.sv */
`timescale 1ns/1ns
module annun_operator (
  // Clock.
  input  wire logic        clk_sys,
  // Request: one-hot button set and hold time in cycles.
  input  wire logic [2:0]  press_req,
  input  wire logic [15:0] hold_cyc,
  // Buttons and state.
  output logic [2:0]       buttons = 3'h0,
  output logic             busy = 1'b0
);
  logic [15:0] cnt_ff = 16'h0;
  // Holds the button, then keeps it released long enough to debounce.
  always_ff @(posedge clk_sys) begin
    if (press_req != 3'h0 && !busy) begin
      buttons <= press_req;
      cnt_ff  <= hold_cyc + 16'h64;
      busy    <= 1'b1;
    end else if (busy) begin
      cnt_ff <= cnt_ff - 16'h1;
      if (cnt_ff == 16'h64) begin
        buttons <= 3'h0;
      end
      if (cnt_ff == 16'h1) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

/* tb/annunciator_config_menu_tb.sv */
`timescale 1ns/1ns
module annunciator_config_menu_tb;
  logic                clk_sys = 1'b0;
  logic                rst_b = 1'b0;
  logic [2:0]          press_req = 3'h0;
  logic [15:0]         hold_cyc = 16'h0;
  logic [2:0]          buttons;
  logic                busy;
  logic [19:0]         hw_inputs = 20'h0;
  logic [19:0][1:0]    lamp_color;
  logic                ind_a, ind_b, ind_c, horn_on, horn_loud, save_strobe, irq;
  annun_cfg_pkg::cfg_s cfg_out;
  logic [7:0]          reg_addr = 8'h0;
  logic [31:0]         reg_wdata = 32'h0, reg_rdata, rv;
  logic                reg_wr = 1'b0, reg_rd = 1'b0;
  int                  mismatches = 0, num_checks = 0, saves = 0, n, k, c;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (save_strobe === 1'b1) saves <= saves + 1;
  annun_operator i_annun_operator (.clk_sys(clk_sys), .press_req(press_req),
    .hold_cyc(hold_cyc), .buttons(buttons), .busy(busy));
  annunciator_config_menu #(.MS_CYCLES(4)) i_annunciator_config_menu (
    .clk_sys(clk_sys), .rst_b(rst_b), .function_select_button(buttons[0]),
    .lamp_step_button(buttons[1]), .value_step_button(buttons[2]), .hw_inputs(hw_inputs),
    .lamp_color(lamp_color), .config_indicator_a(ind_a), .config_indicator_b(ind_b),
    .config_indicator_c(ind_c), .horn_on(horn_on), .horn_loud(horn_loud),
    .save_strobe(save_strobe), .cfg_out(cfg_out), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic col_chk(input int i, input logic [1:0] exp);
    chk({30'h0, lamp_color[i]}, {30'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
  endtask
  task automatic press(input logic [2:0] b, input int reps, input logic [15:0] hold);
    repeat (reps) begin
      @(posedge clk_sys);
      press_req <= b;
      hold_cyc <= hold;
      @(posedge clk_sys);
      press_req <= 3'h0;
      @(negedge clk_sys);
      while (busy) @(negedge clk_sys);
    end
  endtask
  task automatic count_on(input int i);
    c = 0;
    repeat (4000) begin
      @(negedge clk_sys);
      c += (lamp_color[i] == 2'h1);
    end
  endtask
  task automatic leave();
    n = saves;
    press(3'h1, 1, 16'h4fb0);
    k = 0;
    repeat (12000) begin
      @(negedge clk_sys);
      k += ind_c;
    end
    chk(saves - n, 1);
    chk(k > 0 && k < 12000, 1);
  endtask
  function automatic logic [1:0] batt_col(input int b);
    return (b == 0) ? 2'h1 : (b == 2 || b == 4) ? 2'h3 : 2'h2;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(32'h60736ee2));
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(8'h10);
    chk(rv, 32'h89);
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h1);
    rd(8'h04);
    chk(rv & 32'h3f, 32'h0a);
    chk({31'h0, irq}, 32'h0);
    wr(8'h0c, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    wr(8'h08, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    rd(8'h40);
    chk(rv, 32'h0);
    $display("test registers done");
    n = $urandom_range(6, 1);
    press(3'h4, n, 16'h64);
    chk({ind_c, ind_b, ind_a}, 3'b001);
    col_chk(10, batt_col((1 + n) % 5));
    col_chk(12, ((1 + n) % 5 >= 3) ? 2'h0 : batt_col((1 + n) % 5));
    press(3'h1, 1, 16'h64);
    chk({ind_c, ind_b, ind_a}, 3'b010);
    press(3'h4, 1, 16'h64);
    for (int i = 0; i < 20; i++) col_chk(i, 2'h1);
    press(3'h1, 1, 16'h64);
    k = $urandom_range(7, 0);
    press(3'h4, k, 16'h64);
    for (int i = 0; i < 4; i++) col_chk(i, (i == k % 4) ? 2'h1 : 2'h0);
    press(3'h1, 1, 16'h64);
    press(3'h4, 6, 16'h64);
    col_chk(0, 2'h0);
    press(3'h2, 1, 16'h64);
    press(3'h4, 3, 16'h64);
    count_on(1);
    chk(c, 1024);
    press(3'h2, 1, 16'h64);
    count_on(1);
    chk(c, 2000);
    press(3'h1, 1, 16'h64);
    press(3'h4, 1, 16'h64);
    press(3'h2, 3, 16'h64);
    press(3'h4, 1, 16'h64);
    press(3'h1, 1, 16'h64);
    press(3'h2, 2, 16'h64);
    press(3'h4, 1, 16'h64);
    press(3'h1, 1, 16'h64);
    press(3'h4, 1, 16'h64);
    col_chk(0, 2'h1);
    leave();
    chk(32'(cfg_out.alert), 32'h8);
    chk(32'(cfg_out.invert), 32'h4);
    chk(32'(cfg_out.lamp_cfg[0]), 32'h6);
    chk(32'(cfg_out.horn_lvl), 32'h0);
    $display("test menu done");
    @(posedge clk_sys);
    hw_inputs <= 20'($urandom()) & 20'hffff7;
    repeat (5) @(negedge clk_sys);
    col_chk(0, 2'h0);
    for (int i = 2; i < 20; i++) col_chk(i, (hw_inputs[i] ^ (i == 2)) ? 2'h1 : 2'h0);
    @(posedge clk_sys);
    hw_inputs[3] <= 1'b1;
    repeat (5) @(negedge clk_sys);
    chk({31'h0, horn_on}, 32'h0);
    wr(8'h00, 32'h1);
    press(3'h1, 6, 16'h64);
    press(3'h4, 1, 16'h64);
    leave();
    @(posedge clk_sys);
    hw_inputs[3] <= 1'b0;
    repeat (5) @(negedge clk_sys);
    @(posedge clk_sys);
    hw_inputs[3] <= 1'b1;
    repeat (5) @(negedge clk_sys);
    chk({30'h0, horn_on, horn_loud}, 32'h2);
    rd(8'h08);
    chk(rv & 32'h4, 32'h4);
    $display("test run done");
    test_done();
  end
endmodule
